// File: core/lad_pkg.sv
package lad_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] VIDEO_BASE = 32'h000A_0000;
  localparam logic [31:0] MONO_BASE = 32'h000B_0000;
  localparam logic [31:0] MONO_END = 32'h000B_8000;
  localparam logic [31:0] EXP_BASE = 32'h000C_0000;
  localparam logic [31:0] SYS_BIOS_BASE = 32'h000F_0000;
  localparam logic [31:0] EXT_MEM_BASE = 32'h0010_0000;
  localparam logic [31:0] HOLE_BASE = 32'h00F0_0000;
  localparam logic [31:0] HOLE_END = 32'h0100_0000;
  localparam int SEG_SHIFT = 14;
  localparam int NUM_SEGS = 13;
  localparam logic [3:0] SYS_BIOS_SEG = 4'hC;

  // Mono adapter I/O ports
  localparam logic [15:0] IO_MONO_A = 16'h03B4;
  localparam logic [15:0] IO_MONO_B = 16'h03B5;
  localparam logic [15:0] IO_MONO_C = 16'h03B8;
  localparam logic [15:0] IO_MONO_D = 16'h03B9;
  localparam logic [15:0] IO_MONO_E = 16'h03BA;
  localparam logic [15:0] IO_MONO_F = 16'h03BF;

  // ----------------------------------------------------------------
  // Registers (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_SEG_READ = 5'h00;
  localparam logic [4:0] OFS_SEG_WRITE = 5'h04;
  localparam logic [4:0] OFS_LEGACY_CTRL = 5'h08;
  localparam logic [4:0] OFS_TOP_OF_MEM = 5'h0C;
  localparam logic [4:0] OFS_GFX_BASE = 5'h10;
  localparam logic [4:0] OFS_GFX_LIMIT = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;
  localparam int CTL_VGA_TO_HUB = 0;
  localparam int CTL_MONO_ADAPTER_PRESENT_BIT = 1;
  localparam int CTL_MM_RAM_ENABLE = 2;
  localparam int CTL_FIXED_HOLE_CONTROL = 3;
  localparam int CTL_GFX_ENABLE = 4;
  localparam int CTL_WIDTH = 5;
  localparam logic [12:0] SEG_RESET = 13'h0000;
  localparam logic [4:0] CTL_RESET = 5'h10;
  localparam logic [31:0] TOM_RESET = 32'h0400_0000;
  localparam logic [31:0] GFX_BASE_RESET = 32'hE000_0000;
  localparam logic [31:0] GFX_LIMIT_RESET = 32'hE7FF_FFFF;

  // ----------------------------------------------------------------
  // Cycle and route carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LAD_TGT_NONE = 2'b00,
    LAD_TGT_DRAM = 2'b01,
    LAD_TGT_GFX = 2'b10,
    LAD_TGT_HUB = 2'b11
  } lad_target_e;

  typedef struct packed {
    logic [31:0] addr;
    logic is_io;
    logic is_write;
    logic mm_mode;
    logic from_hub;
  } lad_cycle_s;

  typedef struct packed {
    logic valid;
    lad_target_e target;
    logic read_zero;
    logic drop_write;
    logic [31:0] addr;
    logic is_write;
  } lad_route_s;

endpackage

// File: core/lad_decoder.sv
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
module lad_decoder (
  input wire logic clock, // System clock, 100 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [4:0] avs_address, // Register byte address
  input wire logic avs_read, // Register read request
  input wire logic avs_write, // Register write request
  input wire logic [31:0] avs_writedata, // Register write data
  input wire logic [3:0] avs_byteenable, // Write byte lanes
  output logic [31:0] avs_readdata, // Register read data
  output logic avs_waitrequest, // Low for one cycle when answered
  input wire logic native_gfx_strap, // Native graphics strap pin
  input wire logic cyc_valid, // Incoming processor or hub cycle
  input wire lad_pkg::lad_cycle_s cyc_in, // Cycle attributes
  output lad_pkg::lad_route_s route_out // Routed cycle, one cycle later
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [12:0] seg_read;
    logic [12:0] seg_write;
    logic [lad_pkg::CTL_WIDTH-1:0] ctrl;
    logic [31:0] top_of_mem;
    logic [31:0] gfx_base;
    logic [31:0] gfx_limit;
    logic [2:0] strap_sync;
    logic strap;
    logic waitreq;
    logic [31:0] rdata;
    lad_pkg::lad_route_s route;
    logic [1:0] last_tgt;
    logic [15:0] invalid_cnt;
  } lad_state_s;

  lad_state_s st_reg;
  lad_state_s st_next;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] lad_merge(input logic [31:0] old_val,
                                            input logic [31:0] new_val,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Segment 0..7 expansion, 8..11 extended BIOS, 12 system BIOS
  function automatic logic [3:0] lad_seg_index(input logic [31:0] addr);
    logic [3:0] idx;
    idx = 4'h0;
    if (addr >= lad_pkg::SYS_BIOS_BASE) begin
      idx = lad_pkg::SYS_BIOS_SEG;
    end else begin
      idx = 4'(addr[19:lad_pkg::SEG_SHIFT] - 6'h30);
    end
    return idx;
  endfunction

  function automatic logic lad_is_mono_port(input logic [31:0] addr);
    logic [15:0] p;
    p = addr[15:0];
    return (p == lad_pkg::IO_MONO_A) || (p == lad_pkg::IO_MONO_B) ||
           (p == lad_pkg::IO_MONO_C) || (p == lad_pkg::IO_MONO_D) ||
           (p == lad_pkg::IO_MONO_E) || (p == lad_pkg::IO_MONO_F);
  endfunction

  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------
  lad_pkg::lad_target_e tgt;
  logic seg_en;
  logic video_to_gfx;
  logic mono_to_gfx;
  logic in_mono;
  logic gfx_en;

  always_comb begin
    seg_en = 1'b0;
    gfx_en = st_reg.ctrl[lad_pkg::CTL_GFX_ENABLE];
    video_to_gfx = st_reg.strap && !st_reg.ctrl[lad_pkg::CTL_VGA_TO_HUB];
    mono_to_gfx = video_to_gfx && !st_reg.ctrl[lad_pkg::CTL_MONO_ADAPTER_PRESENT_BIT];
    in_mono = (cyc_in.addr >= lad_pkg::MONO_BASE) && (cyc_in.addr < lad_pkg::MONO_END);
    tgt = lad_pkg::LAD_TGT_HUB;
    if (cyc_in.is_io) begin
      if (lad_is_mono_port(cyc_in.addr)) begin
        tgt = mono_to_gfx ? lad_pkg::LAD_TGT_GFX : lad_pkg::LAD_TGT_HUB;
      end
    end else if (cyc_in.addr < lad_pkg::VIDEO_BASE) begin
      tgt = lad_pkg::LAD_TGT_DRAM;
    end else if (cyc_in.addr < lad_pkg::EXP_BASE) begin
      // management RAM only for CPU in that mode
      if (st_reg.ctrl[lad_pkg::CTL_MM_RAM_ENABLE] && cyc_in.mm_mode && !cyc_in.from_hub) begin
        tgt = lad_pkg::LAD_TGT_DRAM;
      end else if (in_mono) begin
        tgt = mono_to_gfx ? lad_pkg::LAD_TGT_GFX : lad_pkg::LAD_TGT_HUB;
      end else begin
        tgt = video_to_gfx ? lad_pkg::LAD_TGT_GFX : lad_pkg::LAD_TGT_HUB;
      end
    end else if (cyc_in.addr < lad_pkg::EXT_MEM_BASE) begin
      if (cyc_in.is_write) begin
        seg_en = st_reg.seg_write[lad_seg_index(cyc_in.addr)];
      end else begin
        seg_en = st_reg.seg_read[lad_seg_index(cyc_in.addr)];
      end
      tgt = seg_en ? lad_pkg::LAD_TGT_DRAM : lad_pkg::LAD_TGT_HUB;
    end else if (cyc_in.addr < st_reg.top_of_mem) begin
      if (st_reg.ctrl[lad_pkg::CTL_FIXED_HOLE_CONTROL] &&
          cyc_in.addr >= lad_pkg::HOLE_BASE && cyc_in.addr < lad_pkg::HOLE_END) begin
        tgt = lad_pkg::LAD_TGT_HUB;
      end else begin
        tgt = lad_pkg::LAD_TGT_DRAM;
      end
    end else begin
      // full 4 GB, graphics window above memory
      if (gfx_en && cyc_in.addr >= st_reg.gfx_base && cyc_in.addr <= st_reg.gfx_limit) begin
        tgt = lad_pkg::LAD_TGT_GFX;
      end else begin
        tgt = lad_pkg::LAD_TGT_HUB;
      end
    end
    // disabled graphics unit makes the target invalid
    if (tgt == lad_pkg::LAD_TGT_GFX && !gfx_en) begin
      tgt = lad_pkg::LAD_TGT_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic req;

  always_comb begin
    st_next = st_reg;
    req = (avs_read || avs_write) && st_reg.waitreq;
    // Strap: three stages, change once stages two and three agree
    st_next.strap_sync = {st_reg.strap_sync[1:0], native_gfx_strap};
    if (st_reg.strap_sync[1] == st_reg.strap_sync[2]) begin
      st_next.strap = st_reg.strap_sync[2];
    end
    // one target per cycle, registered before issue
    st_next.route.valid = cyc_valid;
    st_next.route.target = cyc_valid ? tgt : lad_pkg::LAD_TGT_NONE;
    st_next.route.addr = cyc_in.addr;
    st_next.route.is_write = cyc_in.is_write;
    if (cyc_valid) begin
      st_next.last_tgt = tgt;
    end
    st_next.route.read_zero = cyc_valid && !cyc_in.is_write && tgt == lad_pkg::LAD_TGT_NONE;
    st_next.route.drop_write = cyc_valid && cyc_in.is_write && tgt == lad_pkg::LAD_TGT_NONE;
    if (cyc_valid && tgt == lad_pkg::LAD_TGT_NONE && st_reg.invalid_cnt != 16'hFFFF) begin
      st_next.invalid_cnt = st_reg.invalid_cnt + 16'h0001;
    end
    // Answer one cycle after the request; idle waitrequest stays high
    st_next.waitreq = !req;
    st_next.rdata = 32'h0000_0000;
    // Write lands on the edge that sees waitrequest low, as the master expects
    if (avs_write && !st_reg.waitreq) begin
      if (avs_address == lad_pkg::OFS_SEG_READ) begin
        st_next.seg_read = 13'(lad_merge({19'h0_0000, st_reg.seg_read},
                                         avs_writedata, avs_byteenable));
      end else if (avs_address == lad_pkg::OFS_SEG_WRITE) begin
        st_next.seg_write = 13'(lad_merge({19'h0_0000, st_reg.seg_write},
                                          avs_writedata, avs_byteenable));
      end else if (avs_address == lad_pkg::OFS_LEGACY_CTRL) begin
        st_next.ctrl = 5'(lad_merge({27'h000_0000, st_reg.ctrl},
                                    avs_writedata, avs_byteenable));
      end else if (avs_address == lad_pkg::OFS_TOP_OF_MEM) begin
        st_next.top_of_mem = lad_merge(st_reg.top_of_mem, avs_writedata, avs_byteenable);
      end else if (avs_address == lad_pkg::OFS_GFX_BASE) begin
        st_next.gfx_base = lad_merge(st_reg.gfx_base, avs_writedata, avs_byteenable);
      end else if (avs_address == lad_pkg::OFS_GFX_LIMIT) begin
        st_next.gfx_limit = lad_merge(st_reg.gfx_limit, avs_writedata, avs_byteenable);
      end
    end else if (req && avs_read) begin
      if (avs_address == lad_pkg::OFS_SEG_READ) begin
        st_next.rdata = {19'h0_0000, st_reg.seg_read};
      end else if (avs_address == lad_pkg::OFS_SEG_WRITE) begin
        st_next.rdata = {19'h0_0000, st_reg.seg_write};
      end else if (avs_address == lad_pkg::OFS_LEGACY_CTRL) begin
        st_next.rdata = {27'h000_0000, st_reg.ctrl};
      end else if (avs_address == lad_pkg::OFS_TOP_OF_MEM) begin
        st_next.rdata = st_reg.top_of_mem;
      end else if (avs_address == lad_pkg::OFS_GFX_BASE) begin
        st_next.rdata = st_reg.gfx_base;
      end else if (avs_address == lad_pkg::OFS_GFX_LIMIT) begin
        st_next.rdata = st_reg.gfx_limit;
      end else if (avs_address == lad_pkg::OFS_STATUS) begin
        st_next.rdata = {st_reg.invalid_cnt, 13'h0000, st_reg.last_tgt, st_reg.strap};
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{seg_read: lad_pkg::SEG_RESET, seg_write: lad_pkg::SEG_RESET,
                  ctrl: lad_pkg::CTL_RESET, top_of_mem: lad_pkg::TOM_RESET,
                  gfx_base: lad_pkg::GFX_BASE_RESET, gfx_limit: lad_pkg::GFX_LIMIT_RESET,
                  strap_sync: 3'h0, strap: 1'b0, waitreq: 1'b1, rdata: 32'h0000_0000,
                  route: '0, last_tgt: 2'b00, invalid_cnt: 16'h0000};
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = st_reg.waitreq;
  assign route_out = st_reg.route;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_low_dram_fixed: assert property (
    cyc_valid && !cyc_in.is_io && cyc_in.addr < lad_pkg::VIDEO_BASE
    |=> route_out.valid && route_out.target == lad_pkg::LAD_TGT_DRAM)
    else $error("low 640 KB not routed to DRAM");

  a_seg_read_gate: assert property (
    cyc_valid && !cyc_in.is_io && !cyc_in.is_write && cyc_in.addr >= lad_pkg::EXP_BASE &&
    cyc_in.addr < lad_pkg::EXT_MEM_BASE && !st_reg.seg_read[lad_seg_index(cyc_in.addr)]
    |=> route_out.target == lad_pkg::LAD_TGT_HUB)
    else $error("disabled segment read not sent to hub");

  a_sys_bios_reset: assert property (
    $rose(rst_n) |-> !st_reg.seg_read[12] && !st_reg.seg_write[12])
    else $error("system BIOS segment not disabled after reset");

  a_hole_to_hub: assert property (
    cyc_valid && !cyc_in.is_io && st_reg.ctrl[lad_pkg::CTL_FIXED_HOLE_CONTROL] &&
    cyc_in.addr >= lad_pkg::HOLE_BASE && cyc_in.addr < lad_pkg::HOLE_END &&
    cyc_in.addr < st_reg.top_of_mem
    |=> route_out.target == lad_pkg::LAD_TGT_HUB)
    else $error("open hole access reached DRAM");

  a_hub_no_mmram: assert property (
    cyc_valid && cyc_in.from_hub && !cyc_in.is_io &&
    cyc_in.addr >= lad_pkg::VIDEO_BASE && cyc_in.addr < lad_pkg::EXP_BASE
    |=> route_out.target != lad_pkg::LAD_TGT_DRAM)
    else $error("hub cycle reached management RAM");

  a_mm_to_dram: assert property (
    cyc_valid && !cyc_in.is_io && cyc_in.mm_mode && !cyc_in.from_hub &&
    st_reg.ctrl[lad_pkg::CTL_MM_RAM_ENABLE] &&
    cyc_in.addr >= lad_pkg::VIDEO_BASE && cyc_in.addr < lad_pkg::EXP_BASE
    |=> route_out.target == lad_pkg::LAD_TGT_DRAM)
    else $error("management access missed DRAM");

  a_video_no_strap: assert property (
    cyc_valid && !cyc_in.is_io && !st_reg.strap && !cyc_in.mm_mode &&
    cyc_in.addr >= lad_pkg::VIDEO_BASE && cyc_in.addr < lad_pkg::EXP_BASE
    |=> route_out.target == lad_pkg::LAD_TGT_HUB)
    else $error("video claimed internally without strap");

  a_invalid_zero: assert property (
    route_out.valid && route_out.target == lad_pkg::LAD_TGT_NONE
    |-> route_out.read_zero != route_out.drop_write && route_out.read_zero == !route_out.is_write)
    else $error("invalid cycle not dropped or zeroed");

  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not exactly one cycle");

  a_mono_io_hub: assert property (
    cyc_valid && cyc_in.is_io && lad_is_mono_port(cyc_in.addr) &&
    st_reg.ctrl[lad_pkg::CTL_MONO_ADAPTER_PRESENT_BIT]
    |=> route_out.target == lad_pkg::LAD_TGT_HUB)
    else $error("mono port not sent to hub with adapter present");

  a_mono_mem_hub: assert property (
    cyc_valid && !cyc_in.is_io && !cyc_in.mm_mode &&
    cyc_in.addr >= lad_pkg::MONO_BASE && cyc_in.addr < lad_pkg::MONO_END &&
    st_reg.ctrl[lad_pkg::CTL_MONO_ADAPTER_PRESENT_BIT]
    |=> route_out.target == lad_pkg::LAD_TGT_HUB)
    else $error("mono range not sent to hub with adapter present");

  a_video_gfx_first: assert property (
    cyc_valid && !cyc_in.is_io && !cyc_in.mm_mode && st_reg.strap &&
    !st_reg.ctrl[lad_pkg::CTL_VGA_TO_HUB] && st_reg.ctrl[lad_pkg::CTL_GFX_ENABLE] &&
    cyc_in.addr >= lad_pkg::VIDEO_BASE && cyc_in.addr < lad_pkg::MONO_BASE
    |=> route_out.target == lad_pkg::LAD_TGT_GFX)
    else $error("graphics unit did not claim video cycle");

  a_plain_video: assert property (
    cyc_valid && !cyc_in.is_io && !cyc_in.mm_mode &&
    cyc_in.addr >= lad_pkg::VIDEO_BASE && cyc_in.addr < lad_pkg::EXP_BASE
    |=> route_out.target != lad_pkg::LAD_TGT_DRAM)
    else $error("non-management video cycle reached DRAM");

  a_seg_write_gate: assert property (
    cyc_valid && !cyc_in.is_io && cyc_in.is_write && cyc_in.addr >= lad_pkg::EXP_BASE &&
    cyc_in.addr < lad_pkg::EXT_MEM_BASE && !st_reg.seg_write[lad_seg_index(cyc_in.addr)]
    |=> route_out.target == lad_pkg::LAD_TGT_HUB)
    else $error("disabled segment write not sent to hub");

  a_seg_shadow: assert property (
    cyc_valid && !cyc_in.is_io && !cyc_in.is_write && cyc_in.addr >= lad_pkg::EXP_BASE &&
    cyc_in.addr < lad_pkg::EXT_MEM_BASE && st_reg.seg_read[lad_seg_index(cyc_in.addr)]
    |=> route_out.target == lad_pkg::LAD_TGT_DRAM)
    else $error("enabled segment read missed DRAM");

  a_main_dram: assert property (
    cyc_valid && !cyc_in.is_io && cyc_in.addr >= lad_pkg::EXT_MEM_BASE &&
    cyc_in.addr < st_reg.top_of_mem &&
    !(cyc_in.addr >= lad_pkg::HOLE_BASE && cyc_in.addr < lad_pkg::HOLE_END)
    |=> route_out.target == lad_pkg::LAD_TGT_DRAM)
    else $error("main memory access missed DRAM");

  a_no_relocate: assert property (
    cyc_valid && !cyc_in.is_io && cyc_in.addr >= lad_pkg::EXT_MEM_BASE &&
    cyc_in.addr >= st_reg.top_of_mem
    |=> route_out.target != lad_pkg::LAD_TGT_DRAM)
    else $error("access above top of memory reached DRAM");

  a_pci_to_hub: assert property (
    cyc_valid && !cyc_in.is_io && cyc_in.addr >= lad_pkg::EXT_MEM_BASE &&
    cyc_in.addr >= st_reg.top_of_mem && !st_reg.ctrl[lad_pkg::CTL_GFX_ENABLE]
    |=> route_out.target == lad_pkg::LAD_TGT_HUB)
    else $error("access above top of memory not sent to hub");

  a_route_pulse: assert property (
    cyc_valid |=> route_out.valid && route_out.addr == $past(cyc_in.addr))
    else $error("routed cycle missing or wrong address");

  a_idle_none: assert property (
    !cyc_valid |=> !route_out.valid && route_out.target == lad_pkg::LAD_TGT_NONE)
    else $error("route issued without an incoming cycle");

  c_hole_cycle: cover property (
    cyc_valid && st_reg.ctrl[lad_pkg::CTL_FIXED_HOLE_CONTROL] && cyc_in.addr == lad_pkg::HOLE_BASE);
  c_gfx_route: cover property (route_out.valid && route_out.target == lad_pkg::LAD_TGT_GFX);
  c_shadow_bios: cover property (
    route_out.valid && route_out.target == lad_pkg::LAD_TGT_DRAM &&
    route_out.addr >= lad_pkg::SYS_BIOS_BASE && route_out.addr < lad_pkg::EXT_MEM_BASE);
  c_invalid: cover property (route_out.valid && route_out.target == lad_pkg::LAD_TGT_NONE);

endmodule

// File: tb/lad_host_model.sv
`timescale 1ns/10ps
module lad_host_model (
  input wire logic clock, // Host clock
  output logic cyc_valid, // Cycle strobe
  output lad_pkg::lad_cycle_s cyc_in // Cycle attributes
);
  initial begin
    cyc_valid = 1'b0;
    cyc_in = '0;
  end

  // One cycle, strobe held for exactly one taking edge
  task automatic send(input lad_pkg::lad_cycle_s c);
    cyc_valid <= 1'b1;
    cyc_in <= c;
    @(posedge clock);
    cyc_valid <= 1'b0;
    // Released lines show the inverse so a stale value never matches
    cyc_in <= ~c;
  endtask
endmodule

// File: tb/legacy_address_decoder_bench.sv
`timescale 1ns/10ps
module legacy_address_decoder_bench;
  logic clock;
  logic rst_n;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic native_gfx_strap;
  logic cyc_valid;
  lad_pkg::lad_cycle_s cyc_in;
  lad_pkg::lad_route_s route;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] m_reg [0:5];
  logic m_strap;
  int inval_cnt;
  logic [1:0] last_tgt;

  lad_decoder dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .native_gfx_strap(native_gfx_strap),
    .cyc_valid(cyc_valid), .cyc_in(cyc_in), .route_out(route));
  lad_host_model host (.clock(clock), .cyc_valid(cyc_valid), .cyc_in(cyc_in));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ------------------------------------------------------------
  // Register bus master and register model
  // ------------------------------------------------------------
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    // No wait limit here: the hang guard ends a stuck transfer
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  function automatic logic [31:0] exp_rd(input logic [4:0] a);
    if (a == 5'h18) return {inval_cnt[15:0], 13'h0000, last_tgt, m_strap};
    if (a < 5'h18) return m_reg[a[4:2]];
    return 32'h0000_0000;
  endfunction

  task automatic wreg(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
    if (a < 5'h18) begin
      for (int i = 0; i < 4; i++) if (be[i]) m_reg[a[4:2]][8*i +: 8] = d[8*i +: 8];
      // Reserved bits stay zero
      if (a < 5'h08) m_reg[a[4:2]] &= 32'h0000_1FFF;
      if (a == 5'h08) m_reg[2] &= 32'h0000_001F;
    end
  endtask

  task automatic rreg(input logic [4:0] a);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'($urandom), q);
    check(64'(q), 64'(exp_rd(a)));
  endtask

  // ------------------------------------------------------------
  // Reference routing model
  // ------------------------------------------------------------
  function automatic lad_pkg::lad_route_s exp_route(input lad_pkg::lad_cycle_s c);
    lad_pkg::lad_route_s r;
    logic [31:0] a;
    logic vga;
    logic mono;
    int seg;
    a = c.addr;
    vga = m_strap && !m_reg[2][0];
    mono = vga && !m_reg[2][1];
    r = '0;
    r.valid = 1'b1;
    r.addr = a;
    r.is_write = c.is_write;
    r.target = lad_pkg::LAD_TGT_HUB;
    if (c.is_io) begin
      if (a[15:0] inside {16'h03B4, 16'h03B5, 16'h03B8, 16'h03B9, 16'h03BA, 16'h03BF} && mono)
        r.target = lad_pkg::LAD_TGT_GFX;
    end else if (a < 32'h000A_0000) begin
      r.target = lad_pkg::LAD_TGT_DRAM;
    end else if (a < 32'h000C_0000) begin
      if (m_reg[2][2] && c.mm_mode && !c.from_hub) r.target = lad_pkg::LAD_TGT_DRAM;
      else if (a >= 32'h000B_0000 && a < 32'h000B_8000) begin
        if (mono) r.target = lad_pkg::LAD_TGT_GFX;
      end else if (vga) r.target = lad_pkg::LAD_TGT_GFX;
    end else if (a < 32'h0010_0000) begin
      seg = (a >= 32'h000F_0000) ? 12 : int'((a - 32'h000C_0000) >> 14);
      if (c.is_write ? m_reg[1][seg] : m_reg[0][seg]) r.target = lad_pkg::LAD_TGT_DRAM;
    end else if (a < m_reg[3]) begin
      // Open hole under top of memory leaves the cycle on the hub
      if (!(m_reg[2][3] && a >= 32'h00F0_0000 && a < 32'h0100_0000))
        r.target = lad_pkg::LAD_TGT_DRAM;
    end else if (m_reg[2][4] && a >= m_reg[4] && a <= m_reg[5]) begin
      r.target = lad_pkg::LAD_TGT_GFX;
    end
    if (r.target == lad_pkg::LAD_TGT_GFX && !m_reg[2][4]) begin
      r.target = lad_pkg::LAD_TGT_NONE;
      r.read_zero = !c.is_write;
      r.drop_write = c.is_write;
    end
    return r;
  endfunction

  task automatic cyc(input logic [31:0] a, input logic io, input logic wr, input logic mm,
                     input logic hb);
    lad_pkg::lad_cycle_s c;
    lad_pkg::lad_route_s e;
    c = '{addr: a, is_io: io, is_write: wr, mm_mode: mm, from_hub: hb};
    e = exp_route(c);
    host.send(c);
    @(posedge clock);
    check(64'(route), 64'(e));
    if (e.target == lad_pkg::LAD_TGT_NONE && inval_cnt < 65535) inval_cnt++;
    last_tgt = e.target;
  endtask

  task automatic rnd_cyc(input int nb);
    logic [31:0] b [0:11];
    logic [31:0] a;
    logic io;
    b = '{32'h000A_0000, 32'h000B_0000, 32'h000B_8000, 32'h000C_0000, 32'h000E_0000,
          32'h000F_0000, 32'h0010_0000, 32'h00F0_0000, 32'h0100_0000, m_reg[3], m_reg[4],
          m_reg[5]};
    a = b[$urandom % nb] + ($urandom % 32'h0002_0000) - 32'h0001_0000;
    io = ($urandom % 8 == 0);
    if (io) a = 32'h0000_03B0 + ($urandom % 16);
    cyc(a, io, 1'($urandom), 1'($urandom), 1'($urandom));
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] dir [0:21];
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    native_gfx_strap = 1'b1;
    m_reg = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0010, 32'h0400_0000, 32'hE000_0000,
              32'hE7FF_FFFF};
    m_strap = 1'b1;
    inval_cnt = 0;
    last_tgt = 2'b00;
    dir = '{32'h0000_0000, 32'h0009_FFFF, 32'h000A_0000, 32'h000B_0000, 32'h000B_7FFF,
            32'h000B_8000, 32'h000B_FFFF, 32'h000C_0000, 32'h000E_FFFF, 32'h000F_0000,
            32'h000F_FFFF, 32'h0010_0000, 32'h00EF_FFFF, 32'h00F0_0000, 32'h03FF_FFFF,
            32'h0400_0000, 32'hDFFF_FFFF, 32'hE000_0000, 32'hE7FF_FFFF, 32'hE800_0000,
            32'hFEC0_0000, 32'hFFFF_FFFF};
    void'($urandom(64122));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    for (int i = 0; i < 8; i++) rreg(5'(i * 4));
    foreach (dir[i]) begin
      cyc(dir[i], 1'b0, 1'b0, 1'b0, 1'b0);
      cyc(dir[i], 1'b0, 1'b1, 1'b1, 1'b0);
    end
    // every steering setting, strapped and not
    for (int s = 0; s < 2; s++) begin
      native_gfx_strap <= 1'(s);
      repeat (6) @(posedge clock);
      m_strap = 1'(s);
      for (int k = 0; k < 32; k++) begin
        wreg(5'h08, 32'(k), 4'hF);
        repeat (6) rnd_cyc(3);
        repeat (2) rnd_cyc(9);
      end
    end
    for (int it = 0; it < 2000; it++) begin
      case ($urandom % 8)
        0: wreg(5'($urandom % 8) << 2, $urandom, 4'($urandom));
        1: rreg(5'($urandom % 8) << 2);
        2: begin
          native_gfx_strap <= 1'($urandom);
          repeat (6) @(posedge clock);
          m_strap = native_gfx_strap;
        end
        default: rnd_cyc(12);
      endcase
    end
    for (int i = 0; i < 8; i++) rreg(5'(i * 4));
    summarize();
  end
endmodule
